// ==== hw/swhp_host_port.v ====
// host access port and shared pcm pin roles of the switch
`timescale 1ns/1ps
`default_nettype none
`include "swhp_regs.vh"

module swhp_host_port (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        cs_b,
  input  wire        rd_b,
  input  wire        wr_b,
  input  wire        reg_path_select,
  input  wire [7:0]  host_bus_in,
  output reg  [7:0]  host_bus_out,
  output reg         host_bus_oe,
  input  wire        frame_sync_pulse,
  input  wire        dev_clk,
  input  wire [15:0] pcm_rx_lane_in,
  output reg         driver_tristate_ctrl_0,
  output reg         driver_tristate_ctrl_0_oe,
  output reg         driver_tristate_ctrl_1,
  output reg         driver_tristate_ctrl_1_oe,
  output reg         driver_tristate_ctrl_2,
  output reg         driver_tristate_ctrl_2_oe,
  output reg         driver_tristate_ctrl_3,
  output reg         driver_tristate_ctrl_3_oe,
  output reg         pcm_bit_clock_out,
  output reg         pcm_bit_clock_oe
);

  reg  [`SWHP_SYNC_W-1:0] sync1;
  reg  [`SWHP_SYNC_W-1:0] sync2;
  reg                     rd_d;
  reg                     wr_d;
  reg                     dclk_d;
  reg  [7:0]              mode;
  reg  [3:0]              ptr;
  reg                     primary;
  reg  [1:0]              dcl_cnt;
  wire                    sel;
  wire                    rd_s;
  wire                    wr_s;
  wire                    a0_s;
  wire                    sp_s;
  wire                    dclk_s;
  wire [7:0]              data_s;
  wire [15:0]             lanes_s;
  wire                    rd_fall;
  wire                    wr_rise;
  wire                    dclk_rise;
  wire [15:0]             lane_mask;
  wire [1:0]              dcl_div;
  wire [7:0]              status;
  wire [7:0]              rx_byte;
  wire                    frame_locked;

  // two-stage synchroniser for every pin input
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= `SWHP_SYNC_RST;
      sync2 <= `SWHP_SYNC_RST;
    end else if (ce) begin
      sync1 <= {cs_b, rd_b, wr_b, reg_path_select, frame_sync_pulse,
                dev_clk, host_bus_in, pcm_rx_lane_in};
      sync2 <= sync1;
    end
  end

  // synchronised pin views
  assign sel     = ~sync2[`SWHP_SI_CS];
  assign rd_s    = sync2[`SWHP_SI_RD];
  assign wr_s    = sync2[`SWHP_SI_WR];
  assign a0_s    = sync2[`SWHP_SI_A0];
  assign sp_s    = sync2[`SWHP_SI_SP];
  assign dclk_s  = sync2[`SWHP_SI_DCLK];
  assign data_s  = sync2[23:16];
  assign lanes_s = sync2[15:0];

  // edge history taken from the second stage only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_d   <= 1'b1;
      wr_d   <= 1'b1;
      dclk_d <= 1'b0;
    end else if (ce) begin
      rd_d   <= rd_s;
      wr_d   <= wr_s;
      dclk_d <= dclk_s;
    end
  end

  // strobe edges qualified by chip select, device clock edge unqualified
  assign rd_fall   = sel & ~rd_s & rd_d;
  assign wr_rise   = sel & wr_s & ~wr_d;
  assign dclk_rise = dclk_s & ~dclk_d;

  // status word: frame lock, active pin role, clock selection
  assign status = {5'h00,
                   mode[`SWHP_MODE_CLK8192],
                   primary,
                   frame_locked};

  // mode register and indirect pointer written on the write strobe edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= `SWHP_MODE_RESET;
      ptr  <= `SWHP_PTR_RESET;
    end else if (ce && wr_rise) begin
      if (a0_s) begin
        ptr <= data_s[3:0];
      end else begin
        mode <= data_s;
      end
    end
  end

  // read data latched at the falling read edge, driven until the read strobe or chip select goes high
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_bus_out <= 8'h00;
      host_bus_oe  <= 1'b0;
    end else if (ce) begin
      if (rd_fall) begin
        host_bus_out <= a0_s ? rx_byte : status;
        host_bus_oe  <= 1'b1;
      end else if (!sel || rd_s) begin
        host_bus_oe  <= 1'b0;
      end
    end
  end

  // applied pin role follows the stored mode bit only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primary <= 1'b0;
    end else if (ce) begin
      primary <= mode[`SWHP_MODE_PRIMARY];
    end
  end

  // tristate control pins driven only in primary access role
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      driver_tristate_ctrl_0    <= 1'b0;
      driver_tristate_ctrl_1    <= 1'b0;
      driver_tristate_ctrl_2    <= 1'b0;
      driver_tristate_ctrl_3    <= 1'b0;
      driver_tristate_ctrl_0_oe <= 1'b0;
      driver_tristate_ctrl_1_oe <= 1'b0;
      driver_tristate_ctrl_2_oe <= 1'b0;
      driver_tristate_ctrl_3_oe <= 1'b0;
    end else if (ce) begin
      driver_tristate_ctrl_0    <= primary & mode[`SWHP_MODE_TSC_LSB];
      driver_tristate_ctrl_1    <= primary & mode[`SWHP_MODE_TSC_LSB + 1];
      driver_tristate_ctrl_2    <= primary & mode[`SWHP_MODE_TSC_LSB + 2];
      driver_tristate_ctrl_3    <= primary & mode[`SWHP_MODE_TSC_LSB + 3];
      driver_tristate_ctrl_0_oe <= primary;
      driver_tristate_ctrl_1_oe <= primary;
      driver_tristate_ctrl_2_oe <= primary;
      driver_tristate_ctrl_3_oe <= primary;
    end
  end

  // device clock rises per data clock half period
  assign dcl_div = mode[`SWHP_MODE_CLK8192] ? `SWHP_DCL_DIV_HI
                                             : `SWHP_DCL_DIV_LO;

  // 2048 kHz data clock divided from the device clock edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dcl_cnt           <= 2'h0;
      pcm_bit_clock_out <= 1'b0;
      pcm_bit_clock_oe  <= 1'b0;
    end else if (ce) begin
      pcm_bit_clock_oe <= primary;
      if (!primary) begin
        dcl_cnt           <= 2'h0;
        pcm_bit_clock_out <= 1'b0;
      end else if (dclk_rise) begin
        if (dcl_cnt + 2'h1 >= dcl_div) begin
          dcl_cnt           <= 2'h0;
          pcm_bit_clock_out <= ~pcm_bit_clock_out;
        end else begin
          dcl_cnt <= dcl_cnt + 2'h1;
        end
      end
    end
  end

  // lanes whose pins are outputs are not sampled
  assign lane_mask = primary ? `SWHP_SHARED_LANES : 16'h0000;

  swhp_pcm_rx u_rx (
    .clk          (clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .dev_clk_rise (dclk_rise),
    .sync_pulse   (sp_s),
    .lane_in      (lanes_s),
    .lane_mask    (lane_mask),
    .lane_sel     (ptr),
    .rx_byte      (rx_byte),
    .frame_locked (frame_locked)
  );

endmodule // swhp_host_port

`default_nettype wire

// ==== hw/swhp_pcm_rx.v ====
// serial pcm lane sampler with frame alignment
`timescale 1ns/1ps
`default_nettype none

module swhp_pcm_rx (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        dev_clk_rise,
  input  wire        sync_pulse,
  input  wire [15:0] lane_in,
  input  wire [15:0] lane_mask,
  input  wire [3:0]  lane_sel,
  output reg  [7:0]  rx_byte,
  output reg         frame_locked
);

  reg [7:0] shift [0:15];
  reg [7:0] cap   [0:15];
  reg [2:0] bit_cnt;
  integer   i;

  // one serial bit appended to a lane's shift register, msb first
  function [7:0] shift_in(input [7:0] cur, input bit_in);
    shift_in = {cur[6:0], bit_in};
  endfunction

  // bit counter restarts on the sync pulse, lock flag set on first pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt      <= 3'h0;
      frame_locked <= 1'b0;
    end else if (ce && dev_clk_rise) begin
      if (sync_pulse) begin
        bit_cnt      <= 3'h0;
        frame_locked <= 1'b1;
      end else begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // shift every lane on each device clock rise, masked lanes read zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 16; i = i + 1) begin
        shift[i] <= 8'h00;
        cap[i]   <= 8'h00;
      end
    end else if (ce && dev_clk_rise) begin
      for (i = 0; i < 16; i = i + 1) begin
        shift[i] <= shift_in(shift[i], lane_in[i] & ~lane_mask[i]);
        // eighth bit of the frame arrives while the counter moves to 7
        if (bit_cnt == 3'h6 && !sync_pulse) begin
          cap[i] <= shift_in(shift[i], lane_in[i] & ~lane_mask[i]);
        end
      end
    end
  end

  // registered view of the selected lane's last complete byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_byte <= 8'h00;
    end else if (ce) begin
      rx_byte <= cap[lane_sel];
    end
  end

endmodule // swhp_pcm_rx

`default_nettype wire

// ==== hw/swhp_regs.vh ====
// constants for the switch host port and pcm pin roles
`ifndef SWHP_REGS_VH
`define SWHP_REGS_VH

// mode register fields (written with reg_path_select low)
`define SWHP_MODE_RESET      8'h00
`define SWHP_MODE_PRIMARY    0
`define SWHP_MODE_CLK8192    1
`define SWHP_MODE_TSC_LSB    4

// status register fields (read with reg_path_select low)
`define SWHP_STAT_LOCK       0
`define SWHP_STAT_PRIMARY    1
`define SWHP_STAT_CLK8192    2

// indirect pointer reset value and lane select width
`define SWHP_PTR_RESET       4'h0

// lanes whose pins take other roles in primary access configuration
`define SWHP_SHARED_LANES    16'h1119

// synchroniser layout and reset value (strobes idle high)
`define SWHP_SYNC_W          30
`define SWHP_SYNC_RST        30'h38000000
`define SWHP_SI_CS           29
`define SWHP_SI_RD           28
`define SWHP_SI_WR           27
`define SWHP_SI_A0           26
`define SWHP_SI_SP           25
`define SWHP_SI_DCLK         24

// data clock figures in kHz and the resulting divide counts
`define SWHP_DCL_KHZ         2048
`define SWHP_DEV_KHZ_LO      4096
`define SWHP_DEV_KHZ_HI      8192
// divide counts are device kHz / (2 * data clock kHz), sized for the counter
`define SWHP_DCL_DIV_LO      2'h1
`define SWHP_DCL_DIV_HI      2'h2

`endif

// ==== test/swhp_monitor.sv ====
// assertion checker for the switch host port
`timescale 1ns/1ps
`default_nettype none
module swhp_monitor (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       rd_b,
  input wire logic       reg_path_select,
  input wire logic [7:0] host_bus_out,
  input wire logic       host_bus_oe,
  input wire logic       driver_tristate_ctrl_0,
  input wire logic       driver_tristate_ctrl_0_oe,
  input wire logic       driver_tristate_ctrl_3_oe,
  input wire logic       pcm_bit_clock_out,
  input wire logic       pcm_bit_clock_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // data bus drive follows a selected read
  a_read_drive_start: assert property (
    $fell(rd_b) ##0 (!cs_b && !rd_b)[*5] |-> host_bus_oe)
    else $error("bus not driven in selected read");
  a_oe_release: assert property (
    (rd_b || cs_b)[*5] |-> !host_bus_oe)
    else $error("bus driven outside selected read");
  a_bus_hold: assert property (
    host_bus_oe && $past(host_bus_oe) |-> $stable(host_bus_out))
    else $error("read data moved while driven");
  a_status_form: assert property (
    $rose(host_bus_oe) && !$past(reg_path_select, 3)
    |-> host_bus_out[7:3] == 5'h00 && host_bus_out[1] == pcm_bit_clock_oe)
    else $error("status layout wrong");
  // pin roles follow the stored mode only
  a_role_change: assert property (
    $changed(pcm_bit_clock_oe)
    |-> !$past(cs_b, 6) && !$past(reg_path_select, 6))
    else $error("pin role changed without mode write");
  a_roles_agree: assert property (
    driver_tristate_ctrl_0_oe == pcm_bit_clock_oe
    && driver_tristate_ctrl_3_oe == pcm_bit_clock_oe)
    else $error("shared pin enables disagree");
  a_tsc_gated: assert property (
    driver_tristate_ctrl_0 |-> driver_tristate_ctrl_0_oe)
    else $error("control level high outside primary");
  a_dclk_idle: assert property (
    !pcm_bit_clock_oe |-> !pcm_bit_clock_out)
    else $error("data clock active outside primary");
  a_dclk_rate: assert property (
    $changed(pcm_bit_clock_out)
    |=> ($stable(pcm_bit_clock_out) || !pcm_bit_clock_oe)[*6])
    else $error("data clock toggles too fast");
endmodule // swhp_monitor
bind swhp_host_port swhp_monitor u_mon (.clk(clk), .rst_b(rst_b),
  .cs_b(cs_b), .rd_b(rd_b), .reg_path_select(reg_path_select),
  .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
  .driver_tristate_ctrl_0(driver_tristate_ctrl_0),
  .driver_tristate_ctrl_0_oe(driver_tristate_ctrl_0_oe),
  .driver_tristate_ctrl_3_oe(driver_tristate_ctrl_3_oe),
  .pcm_bit_clock_out(pcm_bit_clock_out),
  .pcm_bit_clock_oe(pcm_bit_clock_oe));
`default_nettype wire

// ==== test/swhp_pcm_source.sv ====
// far end model: device clock, frame sync and serial lanes
`timescale 1ns/1ps
`default_nettype none
module swhp_pcm_source (
  output var logic        dev_clk,
  output var logic        frame_sync_pulse,
  output var logic [15:0] lane
);
  integer     bit_no;
  integer     n;
  logic [7:0] b;
  // free running device clock, phase unrelated to clk
  initial begin
    dev_clk = 1'b0;
    #1;
    forever #100 dev_clk = ~dev_clk;
  end
  // lane n sends {n, ~n} msb first, sync marks bit 0
  initial begin
    bit_no = 0;
    frame_sync_pulse = 1'b0;
    lane = 16'h0000;
    forever begin
      @(negedge dev_clk);
      frame_sync_pulse = (bit_no == 0);
      for (n = 0; n < 16; n = n + 1) begin
        b = {n[3:0], ~n[3:0]};
        lane[n] = b[7 - bit_no];
      end
      bit_no = (bit_no + 1) % 8;
    end
  end
endmodule // swhp_pcm_source
`default_nettype wire

// ==== test/test_switch_host_port_pin_roles.sv ====
// self-checking bench for the switch host port
`timescale 1ns/1ps
`default_nettype none
module test_switch_host_port_pin_roles;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cs_b = 1'b1;
  logic        rd_b = 1'b1;
  logic        wr_b = 1'b1;
  logic        a0 = 1'b0;
  logic [7:0]  cpu_bus = 8'h00;
  logic [7:0]  q;
  integer      bad_count = 0;
  integer      num_checks = 0;
  integer      i;
  wire  [15:0] src;
  wire         dev_clk;
  wire         sync_p;
  wire  [7:0]  bus_out;
  wire         bus_oe;
  wire  [3:0]  tsc;
  wire  [3:0]  tsc_oe;
  wire         dclk;
  wire         dclk_oe;
  // resolve shared pins and the data bus from all enables
  wire  [15:0] msk = {3'h0, tsc_oe[3], 3'h0, tsc_oe[2], 3'h0, tsc_oe[1],
                      dclk_oe, 2'h0, tsc_oe[0]};
  wire  [15:0] drv = {3'h0, tsc[3], 3'h0, tsc[2], 3'h0, tsc[1], dclk,
                      2'h0, tsc[0]};
  wire  [15:0] pins = (src & ~msk) | (drv & msk);
  wire  [7:0]  bus_pin = bus_oe ? bus_out : cpu_bus;
  always #12.5 clk = ~clk;
  swhp_pcm_source u_src (.dev_clk(dev_clk), .frame_sync_pulse(sync_p),
    .lane(src));
  swhp_host_port DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .cs_b(cs_b),
    .rd_b(rd_b), .wr_b(wr_b), .reg_path_select(a0),
    .host_bus_in(bus_pin), .host_bus_out(bus_out), .host_bus_oe(bus_oe),
    .frame_sync_pulse(sync_p), .dev_clk(dev_clk), .pcm_rx_lane_in(pins),
    .driver_tristate_ctrl_0(tsc[0]), .driver_tristate_ctrl_0_oe(tsc_oe[0]),
    .driver_tristate_ctrl_1(tsc[1]), .driver_tristate_ctrl_1_oe(tsc_oe[1]),
    .driver_tristate_ctrl_2(tsc[2]), .driver_tristate_ctrl_2_oe(tsc_oe[2]),
    .driver_tristate_ctrl_3(tsc[3]), .driver_tristate_ctrl_3_oe(tsc_oe[3]),
    .pcm_bit_clock_out(dclk), .pcm_bit_clock_oe(dclk_oe));
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      bad_count = bad_count + 1;
    end
  endtask
  // one host access; s=0 leaves chip select high
  task acc(input logic s, input logic w, input logic a, input logic [7:0] d);
    cs_b = ~s;
    a0 = a;
    cpu_bus = d;
    tick(1);
    if (w) begin
      wr_b = 1'b0;
      tick(6);
      wr_b = 1'b1;
      tick(4);
    end else begin
      rd_b = 1'b0;
      tick(8);
      q = bus_out;
      chk({7'h00, bus_oe}, {7'h00, s});
      rd_b = 1'b1;
      tick(5);
      chk({7'h00, bus_oe}, 8'h00);
    end
    cs_b = 1'b1;
    cpu_bus = ~d;
    tick(3);
  endtask
  task t_status;
    acc(1'b1, 1'b0, 1'b0, 8'h00);
    chk(q & 8'hFE, 8'h00);
    tick(80);
    acc(1'b1, 1'b0, 1'b0, 8'h00);
    chk(q, 8'h01);
  endtask
  task t_unselected;
    acc(1'b0, 1'b1, 1'b0, 8'hF1);
    acc(1'b0, 1'b0, 1'b0, 8'h00);
    chk({3'h0, dclk_oe, tsc_oe}, 8'h00);
  endtask
  // mode write, pin roles, status, every lane, data clock rate
  task t_mode(input logic [7:0] m);
    integer c;
    logic   last;
    acc(1'b1, 1'b1, 1'b0, m);
    tick(200);
    chk({3'h0, dclk_oe, tsc_oe}, m[0] ? 8'h1F : 8'h00);
    chk({4'h0, tsc}, m[0] ? {4'h0, m[7:4]} : 8'h00);
    acc(1'b1, 1'b0, 1'b0, 8'h00);
    chk(q, {5'h00, m[1], m[0], 1'b1});
    for (i = 0; i < 16; i = i + 1) begin
      acc(1'b1, 1'b1, 1'b1, i[7:0]);
      acc(1'b1, 1'b0, 1'b1, 8'h00);
      chk(q, (m[0] && 16'h1119 >> i & 1) ? 8'h00 : {i[3:0], ~i[3:0]});
    end
    c = 0;
    last = dclk;
    repeat (128) begin
      tick(1);
      if (dclk !== last) c = c + 1;
      last = dclk;
    end
    chk(c[7:0], m[0] ? (m[1] ? 8'h08 : 8'h10) : 8'h00);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(6);
    rst_b = 1'b1;
    tick(2);
    t_status;
    t_unselected;
    t_mode(8'h00);
    t_mode(8'hA1);
    t_mode(8'h53);
    t_mode(8'h00);
    report_and_stop;
  end
  // watchdog well past the expected run time
  initial begin
    #500000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // test_switch_host_port_pin_roles
`default_nettype wire
